/* design/rmc_ctrl_word.sv */
module rmc_ctrl_word (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rmc_pkg::RMC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rmc_pkg::rmc_msg_t msg,
  output logic irq,
  output logic busy_resp,
  output logic store_data_en,
  output logic buf_select_b
);

  rmc_pkg::rmc_state_t st_reg;
  rmc_pkg::rmc_state_t st_next;

  logic rx_mode;
  logic cmd_ok;
  logic bcast;
  logic ev_any;
  logic ev_bc;
  logic toggle;
  logic bus_acc;
  logic wr_ctrl;
  logic wr_cfg;
  logic rd_ctrl;
  logic rd_stat;
  logic [15:0] wmask;

  // read data and a hit flag for one address
  function automatic logic [32:0] rd_mux(input logic [7:0] a, input rmc_pkg::rmc_state_t s);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    case (a)
      rmc_pkg::RMC_OFS_CTRL: r = {1'b1, 16'h0000, s.ctrl};
      rmc_pkg::RMC_OFS_CFG: r = {1'b1, 25'h000_0000, s.cfg};
      rmc_pkg::RMC_OFS_STAT: r = {1'b1, 30'h0000_0000, s.stat};
      rmc_pkg::RMC_OFS_MASK: r = {1'b1, 30'h0000_0000, s.mask};
      rmc_pkg::RMC_OFS_LOG: r = {1'b1, 16'h0000, s.log_cnt, 6'h00, s.log_last};
      default: r = {1'b0, 32'h0000_0000};
    endcase
    return r;
  endfunction

  always_comb begin
    logic [32:0] rd;
    rd = rd_mux(paddr, st_reg);
    st_next = st_reg;
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    st_next.store_en = 1'b0;

    // receive mode commands only, and only while the terminal executes
    rx_mode = msg.done && !msg.tr && st_reg.cfg[rmc_pkg::RMC_C_EXEC] &&
      (msg.subaddr == rmc_pkg::RMC_SA_MODE_LO || msg.subaddr == rmc_pkg::RMC_SA_MODE_HI);
    bcast = msg.rt_addr == rmc_pkg::RMC_BCAST_ADDR;
    cmd_ok = rx_mode && msg.valid && !(bcast && st_reg.cfg[rmc_pkg::RMC_C_BCINV]);
    ev_any = cmd_ok && st_reg.ctrl[rmc_pkg::RMC_B_IRQ_ANY] &&
      st_reg.cfg[rmc_pkg::RMC_C_EN_ANY];
    ev_bc = cmd_ok && bcast && st_reg.ctrl[rmc_pkg::RMC_B_IRQ_BC] &&
      st_reg.cfg[rmc_pkg::RMC_C_EN_BC];
    // busy and, with suppression on, illegal messages leave the selector alone
    toggle = cmd_ok && st_reg.cfg[rmc_pkg::RMC_C_PP] && !msg.error &&
      !st_reg.ctrl[rmc_pkg::RMC_B_BUSY] &&
      !(msg.illegal && st_reg.cfg[rmc_pkg::RMC_C_SUPP]);

    // one wait state so that read data comes from a flip-flop
    bus_acc = psel && penable && !st_reg.pready;
    wr_ctrl = bus_acc && pwrite && paddr == rmc_pkg::RMC_OFS_CTRL;
    wr_cfg = bus_acc && pwrite && paddr == rmc_pkg::RMC_OFS_CFG;
    rd_ctrl = bus_acc && !pwrite && paddr == rmc_pkg::RMC_OFS_CTRL;
    rd_stat = bus_acc && !pwrite && paddr == rmc_pkg::RMC_OFS_STAT;
    // ping-pong enable is frozen while executing
    wmask = st_reg.cfg[rmc_pkg::RMC_C_EXEC] ? rmc_pkg::RMC_CTRL_WMASK_RUN
      : rmc_pkg::RMC_CTRL_WMASK_IDLE;

    if (bus_acc) begin
      st_next.pready = 1'b1;
      st_next.pslverr = !rd[32];
      st_next.prdata = pwrite ? 32'h0000_0000 : rd[31:0];
    end
    if (wr_ctrl) begin
      st_next.ctrl = (st_reg.ctrl & ~wmask) | (pwdata[15:0] & wmask);
    end
    if (wr_cfg) begin
      st_next.cfg = pwdata[6:0] & rmc_pkg::RMC_CFG_WMASK;
      if (pwdata[rmc_pkg::RMC_C_SWRST]) begin
        st_next.ctrl[rmc_pkg::RMC_B_ACC] = 1'b0;
        st_next.ctrl[rmc_pkg::RMC_B_SEL] = 1'b0;
      end
    end
    if (bus_acc && pwrite && paddr == rmc_pkg::RMC_OFS_MASK) begin
      st_next.mask = pwdata[1:0];
    end
    if (rd_ctrl) begin
      st_next.ctrl[rmc_pkg::RMC_B_ACC] = 1'b0;
    end
    if (rd_stat) begin
      st_next.stat = rmc_pkg::RMC_EV_RST;
    end

    // hardware updates come last so a same-cycle set beats a clear
    if (cmd_ok) begin
      st_next.ctrl[rmc_pkg::RMC_B_ACC] = 1'b1;
      st_next.store_en = !st_reg.ctrl[rmc_pkg::RMC_B_BUSY] &&
        msg.mode_code >= rmc_pkg::RMC_MC_DATA_MIN;
    end
    if (toggle) begin
      st_next.ctrl[rmc_pkg::RMC_B_SEL] = !st_reg.ctrl[rmc_pkg::RMC_B_SEL];
    end
    if (ev_any || ev_bc) begin
      st_next.stat[rmc_pkg::RMC_E_ANY] = st_next.stat[rmc_pkg::RMC_E_ANY] | ev_any;
      st_next.stat[rmc_pkg::RMC_E_BC] = st_next.stat[rmc_pkg::RMC_E_BC] | ev_bc;
      // log wraps; software sees the count of entries and the latest cause
      st_next.log_cnt = st_reg.log_cnt + 8'h01;
      st_next.log_last = {ev_bc, ev_any};
    end

    st_next.irq = |(st_next.stat & st_next.mask);
    st_next.busy_resp = st_next.ctrl[rmc_pkg::RMC_B_BUSY];
    // indexed buffering always uses pointer A
    st_next.buf_b = st_next.ctrl[rmc_pkg::RMC_B_SEL] && st_next.cfg[rmc_pkg::RMC_C_PP];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.ctrl <= rmc_pkg::RMC_CTRL_RST;
      st_reg.cfg <= rmc_pkg::RMC_CFG_RST;
      st_reg.stat <= rmc_pkg::RMC_EV_RST;
      st_reg.mask <= rmc_pkg::RMC_EV_RST;
      st_reg.log_cnt <= rmc_pkg::RMC_LOG_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign irq = st_reg.irq;
  assign busy_resp = st_reg.busy_resp;
  assign store_data_en = st_reg.store_en;
  assign buf_select_b = st_reg.buf_b;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_any_irq_set: assert property (ev_any |=> st_reg.stat[rmc_pkg::RMC_E_ANY] ##0 irq ||
    !st_reg.mask[rmc_pkg::RMC_E_ANY]) else $error("any-access event not pending");
  chk_irq_pin_level: assert property (irq == |(st_reg.stat & st_reg.mask))
    else $error("interrupt pin disagrees with pending bits");
  chk_log_step: assert property ((ev_any || ev_bc) |=>
    st_reg.log_cnt == $past(st_reg.log_cnt) + 8'h01) else $error("interrupt not logged");
  chk_log_hold: assert property (!(ev_any || ev_bc) |=> $stable(st_reg.log_cnt))
    else $error("log moved without an interrupt");
  chk_stat_sticky: assert property (!ev_any && !ev_bc && !rd_stat |=> $stable(st_reg.stat))
    else $error("pending bits changed without cause");
  chk_bcast_irq_set: assert property (ev_bc |=> st_reg.stat[rmc_pkg::RMC_E_BC])
    else $error("broadcast event not pending");
  chk_bcast_invalid: assert property (msg.done && bcast &&
    st_reg.cfg[rmc_pkg::RMC_C_BCINV] && !bus_acc |=>
    $stable(st_reg.ctrl[rmc_pkg::RMC_B_SEL]) && !store_data_en)
    else $error("invalid broadcast was processed");
  chk_busy_answer: assert property (busy_resp == st_reg.ctrl[rmc_pkg::RMC_B_BUSY])
    else $error("busy answer not following control bit");
  chk_busy_no_store: assert property (cmd_ok && st_reg.ctrl[rmc_pkg::RMC_B_BUSY] &&
    !wr_cfg |=> !store_data_en && $stable(st_reg.ctrl[rmc_pkg::RMC_B_SEL]))
    else $error("busy message stored or toggled");
  chk_store_pulse: assert property (store_data_en |=> !store_data_en || $past(cmd_ok))
    else $error("data store pulse too long");
  chk_store_range: assert property (store_data_en |-> $past(msg.mode_code) >=
    rmc_pkg::RMC_MC_DATA_MIN && !$past(st_reg.ctrl[rmc_pkg::RMC_B_BUSY]))
    else $error("data stored outside its mode codes");
  chk_accessed_set: assert property (cmd_ok |=> st_reg.ctrl[rmc_pkg::RMC_B_ACC] ##1
    st_reg.ctrl[rmc_pkg::RMC_B_ACC] || $past(bus_acc))
    else $error("accessed flag not set");
  chk_accessed_cause: assert property (!cmd_ok |=> !$rose(st_reg.ctrl[rmc_pkg::RMC_B_ACC]))
    else $error("accessed flag set without a message");
  chk_read_clears: assert property (rd_ctrl && !cmd_ok |=> !st_reg.ctrl[rmc_pkg::RMC_B_ACC])
    else $error("read did not clear accessed flag");
  chk_sel_toggle: assert property (toggle |=> st_reg.ctrl[rmc_pkg::RMC_B_SEL] !=
    $past(st_reg.ctrl[rmc_pkg::RMC_B_SEL])) else $error("selector did not invert");
  chk_sel_hold: assert property (!toggle && !(wr_cfg && pwdata[rmc_pkg::RMC_C_SWRST]) |=>
    $stable(st_reg.ctrl[rmc_pkg::RMC_B_SEL])) else $error("selector moved without cause");
  chk_failed_hold: assert property (cmd_ok && msg.error && !wr_cfg |=>
    $stable(st_reg.ctrl[rmc_pkg::RMC_B_SEL])) else $error("failed message moved selector");
  chk_buf_pick: assert property (buf_select_b == (st_reg.ctrl[rmc_pkg::RMC_B_SEL] &&
    st_reg.cfg[rmc_pkg::RMC_C_PP])) else $error("buffer pick wrong");
  chk_ro_bits: assert property (wr_ctrl && !cmd_ok |=>
    st_reg.ctrl[11:8] == $past(st_reg.ctrl[11:8])) else $error("host changed device bits");
  chk_idle_quiet: assert property (msg.done && !st_reg.cfg[rmc_pkg::RMC_C_EXEC] |-> !cmd_ok)
    else $error("message processed while not executing");
  chk_soft_reset: assert property (wr_cfg && pwdata[rmc_pkg::RMC_C_SWRST] && !cmd_ok |=>
    !st_reg.ctrl[rmc_pkg::RMC_B_ACC] && !st_reg.ctrl[rmc_pkg::RMC_B_SEL])
    else $error("software reset left status bits");
  chk_swrst_self_clear: assert property (wr_cfg |=> !st_reg.cfg[rmc_pkg::RMC_C_SWRST])
    else $error("software reset bit stuck");
  chk_tx_ignored: assert property (msg.done && msg.tr |-> !cmd_ok)
    else $error("transmit command processed");
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_slverr_pair: assert property (pslverr |-> pready)
    else $error("error response without ready");

  cov_toggle: cover property (toggle ##1 toggle);
  cov_busy_msg: cover property (cmd_ok && st_reg.ctrl[rmc_pkg::RMC_B_BUSY]);
  cov_any_irq: cover property (ev_any ##[1:20] rd_stat);
  cov_bcast_irq: cover property (ev_bc ##1 irq);
  cov_poll: cover property (cmd_ok ##[1:20] rd_ctrl);

endmodule

/* design/rmc_pkg.sv */
package rmc_pkg;

  localparam int unsigned RMC_ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] RMC_OFS_CTRL = 8'h00;
  localparam logic [7:0] RMC_OFS_CFG = 8'h04;
  localparam logic [7:0] RMC_OFS_STAT = 8'h08;
  localparam logic [7:0] RMC_OFS_MASK = 8'h0c;
  localparam logic [7:0] RMC_OFS_LOG = 8'h10;

  // control word fields
  localparam int unsigned RMC_B_IRQ_ANY = 14;
  localparam int unsigned RMC_B_IRQ_BC = 13;
  localparam int unsigned RMC_B_BUSY = 12;
  localparam int unsigned RMC_B_ACC = 11;
  localparam int unsigned RMC_B_SEL = 10;
  localparam int unsigned RMC_B_STOPP = 3;
  localparam int unsigned RMC_B_PPEN = 2;
  localparam logic [15:0] RMC_CTRL_WMASK_RUN = 16'hf008;
  localparam logic [15:0] RMC_CTRL_WMASK_IDLE = 16'hf00c;
  localparam logic [15:0] RMC_CTRL_RST = 16'h0000;

  // configuration register fields
  localparam int unsigned RMC_C_BCINV = 0;
  localparam int unsigned RMC_C_SUPP = 1;
  localparam int unsigned RMC_C_EN_ANY = 2;
  localparam int unsigned RMC_C_EN_BC = 3;
  localparam int unsigned RMC_C_EXEC = 4;
  localparam int unsigned RMC_C_PP = 5;
  localparam int unsigned RMC_C_SWRST = 6;
  localparam logic [6:0] RMC_CFG_WMASK = 7'h3f;
  localparam logic [6:0] RMC_CFG_RST = 7'h00;

  // event bits of status, mask and log
  localparam int unsigned RMC_E_ANY = 0;
  localparam int unsigned RMC_E_BC = 1;
  localparam logic [1:0] RMC_EV_RST = 2'h0;
  localparam logic [7:0] RMC_LOG_RST = 8'h00;

  // command decode
  localparam logic [4:0] RMC_SA_MODE_LO = 5'h00;
  localparam logic [4:0] RMC_SA_MODE_HI = 5'h1f;
  localparam logic [4:0] RMC_BCAST_ADDR = 5'h1f;
  localparam logic [4:0] RMC_MC_DATA_MIN = 5'h10;

  typedef struct packed {
    logic done;
    logic valid;
    logic illegal;
    logic error;
    logic tr;
    logic [4:0] rt_addr;
    logic [4:0] subaddr;
    logic [4:0] mode_code;
  } rmc_msg_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [6:0] cfg;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [7:0] log_cnt;
    logic [1:0] log_last;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic store_en;
    logic busy_resp;
    logic buf_b;
  } rmc_state_t;

endpackage

/* verification/rmc_bc_model.sv */
module rmc_bc_model (
  input wire logic pclk,
  output rmc_pkg::rmc_msg_t msg
);
  timeunit 1ns;
  timeprecision 1ps;
  initial msg = '0;
  task automatic send(input logic [2:0] q, input logic tr, input logic [4:0] rt,
                      input logic [4:0] sa, input logic [4:0] mc);
    @(posedge pclk);
    // q carries valid, illegal and error of the completed message
    msg <= {1'b1, q, tr, rt, sa, mc};
    @(posedge pclk);
    // qualifiers mean nothing between messages, so scramble them
    msg <= {1'b0, ~msg[18:0]};
  endtask
endmodule

/* verification/rt_rx_mode_ctrl_word_hi_tb.sv */
module rt_rx_mode_ctrl_word_hi_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic irq, busy_resp, store_data_en, buf_select_b;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  rmc_pkg::rmc_msg_t msg;
  int failures = 0;
  int check_count = 0;
  rmc_ctrl_word uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .msg(msg), .irq(irq), .busy_resp(busy_resp),
    .store_data_en(store_data_en), .buf_select_b(buf_select_b));
  rmc_bc_model bc (.pclk(pclk), .msg(msg));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until an edge samples pready high; data is taken at that edge
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("read", rd, exp);
  endtask
  task automatic evq(input logic [2:0] q, input logic tr, input logic [4:0] rt,
                     input logic [4:0] sa, input logic [4:0] mc, input logic [2:0] exp);
    bc.send(q, tr, rt, sa, mc);
    #1;
    chk("irq store sel", {29'h0, irq, store_data_en, buf_select_b}, {29'h0, exp});
  endtask
  task automatic ev(input logic tr, input logic [4:0] rt, input logic [4:0] sa,
                    input logic [4:0] mc, input logic [2:0] exp);
    evq(3'b100, tr, rt, sa, mc, exp);
  endtask
  task automatic t_reset();
    chk("outs", {28'h0, irq, busy_resp, store_data_en, buf_select_b}, 32'h0);
    rdchk(rmc_pkg::RMC_OFS_CTRL, 32'h0);
    rdchk(rmc_pkg::RMC_OFS_STAT, 32'h0);
    rdchk(rmc_pkg::RMC_OFS_LOG, 32'h0);
    apb(1'b1, rmc_pkg::RMC_OFS_CTRL, 32'hffff);
    rdchk(rmc_pkg::RMC_OFS_CTRL, 32'hf00c);
    apb(1'b1, 8'h20, 32'h1);
    chk("slverr", {31'h0, err}, 32'h1);
    $display("test reset and access done");
  endtask
  task automatic t_any();
    apb(1'b1, rmc_pkg::RMC_OFS_CTRL, 32'h6004);
    apb(1'b1, rmc_pkg::RMC_OFS_MASK, 32'h3);
    apb(1'b1, rmc_pkg::RMC_OFS_CFG, 32'h3c);
    ev(1'b0, 5'h05, 5'h00, 5'h11, 3'b111);
    rdchk(rmc_pkg::RMC_OFS_CTRL, 32'h6c04);
    rdchk(rmc_pkg::RMC_OFS_CTRL, 32'h6404);
    rdchk(rmc_pkg::RMC_OFS_STAT, 32'h1);
    chk("irq", {31'h0, irq}, 32'h0);
    apb(1'b0, rmc_pkg::RMC_OFS_LOG, 32'h0);
    chk("log count", rd & 32'hff00, 32'h0100);
    ev(1'b1, 5'h05, 5'h00, 5'h11, 3'b001);
    $display("test any-access done");
  endtask
  task automatic t_bcast();
    ev(1'b0, 5'h1f, 5'h1f, 5'h03, 3'b100);
    rdchk(rmc_pkg::RMC_OFS_STAT, 32'h3);
    apb(1'b1, rmc_pkg::RMC_OFS_CFG, 32'h3d);
    ev(1'b0, 5'h1f, 5'h1f, 5'h14, 3'b000);
    rdchk(rmc_pkg::RMC_OFS_STAT, 32'h0);
    $display("test broadcast done");
  endtask
  task automatic t_busy();
    // suppress left off on purpose: busy must hold the selector by itself
    apb(1'b1, rmc_pkg::RMC_OFS_CFG, 32'h3c);
    apb(1'b1, rmc_pkg::RMC_OFS_CTRL, 32'h7004);
    chk("busy", {31'h0, busy_resp}, 32'h1);
    ev(1'b0, 5'h01, 5'h00, 5'h14, 3'b100);
    rdchk(rmc_pkg::RMC_OFS_STAT, 32'h1);
    $display("test busy done");
  endtask
  task automatic t_swrst();
    apb(1'b1, rmc_pkg::RMC_OFS_CTRL, 32'h6004);
    ev(1'b0, 5'h01, 5'h1f, 5'h12, 3'b111);
    apb(1'b1, rmc_pkg::RMC_OFS_CFG, 32'h7c);
    chk("sel", {31'h0, buf_select_b}, 32'h0);
    rdchk(rmc_pkg::RMC_OFS_CTRL, 32'h6004);
    rdchk(rmc_pkg::RMC_OFS_CFG, 32'h3c);
    apb(1'b1, rmc_pkg::RMC_OFS_MASK, 32'h2);
    rdchk(rmc_pkg::RMC_OFS_STAT, 32'h1);
    ev(1'b0, 5'h01, 5'h00, 5'h01, 3'b001);
    rdchk(rmc_pkg::RMC_OFS_STAT, 32'h1);
    $display("test soft reset and mask done");
  endtask
  task automatic t_flags();
    apb(1'b1, rmc_pkg::RMC_OFS_CFG, 32'h3e);
    evq(3'b110, 1'b0, 5'h01, 5'h00, 5'h15, 3'b011);
    evq(3'b101, 1'b0, 5'h01, 5'h00, 5'h15, 3'b011);
    rdchk(rmc_pkg::RMC_OFS_CTRL, 32'h6c04);
    evq(3'b000, 1'b0, 5'h01, 5'h00, 5'h15, 3'b001);
    rdchk(rmc_pkg::RMC_OFS_CTRL, 32'h6404);
    $display("test message flags done");
  endtask
  task automatic t_mreset();
    apb(1'b1, rmc_pkg::RMC_OFS_CTRL, 32'h7004);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("outs", {28'h0, irq, busy_resp, store_data_en, buf_select_b}, 32'h0);
    presetn <= 1'b1;
    rdchk(rmc_pkg::RMC_OFS_CTRL, 32'h0);
    rdchk(rmc_pkg::RMC_OFS_CFG, 32'h0);
    apb(1'b1, rmc_pkg::RMC_OFS_CFG, 32'h3c);
    chk("sel", {31'h0, buf_select_b}, 32'h0);
    ev(1'b0, 5'h01, 5'h00, 5'h10, 3'b011);
    $display("test master reset done");
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    finish_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_any();
    t_bcast();
    t_busy();
    t_swrst();
    t_flags();
    t_mreset();
    finish_test();
  end
endmodule
